// ---- lcr_host.sv ----
`timescale 1ns/1ps
module lcr_host (
  // clock
  input  wire logic       sys_clk,
  // register port toward the bank
  output logic            wr_en,
  output logic      [7:0] wr_addr,
  output logic      [7:0] wr_data,
  output logic            rd_en,
  output logic      [7:0] rd_addr,
  input  wire logic [7:0] rd_data_r,
  input  wire logic       rd_valid_r
);
  initial begin
    wr_en   = 1'b0;
    rd_en   = 1'b0;
    wr_addr = 8'h00;
    wr_data = 8'h00;
    rd_addr = 8'h00;
  end
  // consecutive calls give back-to-back writes; idle ends the burst
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    rd_en   = 1'b0;
    wr_en   = 1'b1;
    wr_addr = a;
    wr_data = d;
  endtask
  // released lines show the inverse so stale values never look valid
  task automatic idle;
    @(negedge sys_clk);
    wr_en   = 1'b0;
    rd_en   = 1'b0;
    wr_addr = ~wr_addr;
    wr_data = ~wr_data;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(negedge sys_clk);
    wr_en   = 1'b0;
    rd_en   = 1'b1;
    rd_addr = a;
    @(negedge sys_clk);
    rd_en   = 1'b0;
    rd_addr = ~a;
    v       = rd_valid_r;
    d       = rd_data_r;
  endtask
endmodule

// ---- lcr_lane1_cfg.sv ----
`timescale 1ns/1ps
module lcr_lane1_cfg (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic srst,
  // register port from the serial management interface
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_addr,
  input  wire logic [7:0] wr_data,
  input  wire logic       rd_en,
  input  wire logic [7:0] rd_addr,
  output logic      [7:0] rd_data_r,
  output logic            rd_valid_r,
  // idle detector results from the analog front end
  input  wire logic       lane1_output_a_idle_detect,
  input  wire logic       lane1_output_b_idle_detect,
  // equalizer controls
  output logic            lane1_input_eq_enable_r,
  output logic      [1:0] lane1_input_gain_stage_select_r,
  output logic      [2:0] lane1_input_boost_level_select_r,
  // idle thresholds
  output logic      [1:0] lane1_input_idle_deassert_code_r,
  output logic      [1:0] lane1_input_idle_assert_code_r,
  // output swing
  output logic      [6:0] lane1_output_a_output_swing_r,
  output logic      [7:0] lane1_output_a_output_swing_level_r,
  output logic      [6:0] lane1_output_b_output_swing_r,
  output logic      [7:0] lane1_output_b_output_swing_level_r,
  output logic      [1:0] global_swing_scale_r,
  // output idle control
  output logic            lane1_output_a_mute_r,
  output logic            lane1_output_a_signal_detection_en_r,
  output logic            lane1_output_b_mute_r,
  output logic            lane1_output_b_signal_detection_en_r
);

  // ---------------------------------------------------------------
  // register cells
  // ---------------------------------------------------------------
  lcr_wr_if wbus ();

  assign wbus.wr_en   = wr_en;
  assign wbus.wr_addr = wr_addr;
  assign wbus.wr_data = wr_data;

  logic [7:0] reg_val [lcr_pkg::NUM_REG];
  wire  [7:0] rd_term [lcr_pkg::NUM_REG];

  genvar gi;
  generate
    for (gi = 0; gi < lcr_pkg::NUM_REG; gi = gi + 1) begin : g_reg
      lcr_reg_cell #(
        .OFS (lcr_pkg::REG_OFS[gi*8 +: 8]),
        .RST (lcr_pkg::REG_RST[gi*8 +: 8])
      ) u_cell (
        .sys_clk (sys_clk),
        .srst    (srst),
        .wr      (wbus),
        .value_r (reg_val[gi])
      );
      // unmapped offsets match no term and read as zero
      assign rd_term[gi] = (rd_addr == lcr_pkg::REG_OFS[gi*8 +: 8]) ? reg_val[gi] : lcr_pkg::RD_UNMAPPED;
    end
  endgenerate

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  logic [7:0] rd_mux;

  always_comb begin
    rd_mux = lcr_pkg::RD_UNMAPPED;
    for (int i = 0; i < lcr_pkg::NUM_REG; i++) begin
      rd_mux = rd_mux | rd_term[i];
    end
  end

  wire [7:0] rd_data_nxt;
  assign rd_data_nxt = rd_en ? rd_mux : rd_data_r;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rd_data_r  <= lcr_pkg::RD_UNMAPPED;
      rd_valid_r <= 1'b0;
    end else begin
      rd_data_r  <= rd_data_nxt;
      rd_valid_r <= rd_en;
    end
  end

  // ---------------------------------------------------------------
  // idle detect synchronisers
  // ---------------------------------------------------------------
  logic [1:0] idle_meta_r;
  logic [1:0] idle_sync_r;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      idle_meta_r <= 2'h0;
      idle_sync_r <= 2'h0;
    end else begin
      idle_meta_r <= {lane1_output_b_idle_detect, lane1_output_a_idle_detect};
      idle_sync_r <= idle_meta_r;
    end
  end

  // ---------------------------------------------------------------
  // mute control, same encoding on both outputs
  // ---------------------------------------------------------------
  wire [7:0] a_idle_ctl = reg_val[lcr_pkg::IDX_A_IDLE];
  wire [7:0] b_idle_ctl = reg_val[lcr_pkg::IDX_B_IDLE];
  wire       a_mute_nxt;
  wire       b_mute_nxt;

  // auto mode hands muting to the detector; manual mode uses the select bit
  assign a_mute_nxt = a_idle_ctl[lcr_pkg::IDLE_AUTO_BIT] ? idle_sync_r[0]
                                                         : a_idle_ctl[lcr_pkg::IDLE_SEL_BIT];
  assign b_mute_nxt = b_idle_ctl[lcr_pkg::IDLE_AUTO_BIT] ? idle_sync_r[1]
                                                         : b_idle_ctl[lcr_pkg::IDLE_SEL_BIT];

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      lane1_output_a_mute_r                <= 1'b0;
      lane1_output_a_signal_detection_en_r <= 1'b0;
      lane1_output_b_mute_r                <= 1'b0;
      lane1_output_b_signal_detection_en_r <= 1'b0;
    end else begin
      lane1_output_a_mute_r                <= a_mute_nxt;
      lane1_output_a_signal_detection_en_r <= a_idle_ctl[lcr_pkg::IDLE_AUTO_BIT];
      lane1_output_b_mute_r                <= b_mute_nxt;
      lane1_output_b_signal_detection_en_r <= b_idle_ctl[lcr_pkg::IDLE_AUTO_BIT];
    end
  end

  // ---------------------------------------------------------------
  // field taps, registered once more so the analog side sees clean flops
  // ---------------------------------------------------------------
  wire [7:0] eq_reg  = reg_val[lcr_pkg::IDX_EQ];
  wire [7:0] thr_reg = reg_val[lcr_pkg::IDX_IN_IDLE];
  wire       eq_enable_nxt;
  wire [1:0] eq_gain_nxt;
  wire [2:0] eq_boost_nxt;
  wire [1:0] thr_deassert_nxt;
  wire [1:0] thr_assert_nxt;
  wire [6:0] a_swing_nxt;
  wire [7:0] a_level_nxt;
  wire [6:0] b_swing_nxt;
  wire [7:0] b_level_nxt;
  wire [1:0] gscale_nxt;

  assign eq_enable_nxt    = eq_reg[lcr_pkg::EQ_ENABLE_BIT];
  assign eq_gain_nxt      = eq_reg[lcr_pkg::EQ_GAIN_MSB:lcr_pkg::EQ_GAIN_LSB];
  assign eq_boost_nxt     = eq_reg[lcr_pkg::EQ_BOOST_MSB:lcr_pkg::EQ_BOOST_LSB];
  // codes pass as is; the comparator ladder orders 00 lowest to 11 highest
  assign thr_deassert_nxt = thr_reg[lcr_pkg::IDLE_DEA_MSB:lcr_pkg::IDLE_DEA_LSB];
  assign thr_assert_nxt   = thr_reg[lcr_pkg::IDLE_AS_MSB:lcr_pkg::IDLE_AS_LSB];
  // primary swing drops the reserved top bit; level fields are whole bytes
  assign a_swing_nxt      = reg_val[lcr_pkg::IDX_A_SWING1][lcr_pkg::SWING1_MSB:0];
  assign a_level_nxt      = reg_val[lcr_pkg::IDX_A_SWING2][lcr_pkg::SWING2_MSB:0];
  assign b_swing_nxt      = reg_val[lcr_pkg::IDX_B_SWING1][lcr_pkg::SWING1_MSB:0];
  assign b_level_nxt      = reg_val[lcr_pkg::IDX_B_SWING2][lcr_pkg::SWING2_MSB:0];
  assign gscale_nxt       = reg_val[lcr_pkg::IDX_GLOBAL][lcr_pkg::GSCALE_MSB:0];

  // ---------------------------------------------------------------
  // equalizer controls
  // ---------------------------------------------------------------
  // reset mirrors the register default so the equalizer starts enabled
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      lane1_input_eq_enable_r          <= lcr_pkg::RST_EQUALIZER[lcr_pkg::EQ_ENABLE_BIT];
      lane1_input_gain_stage_select_r  <= lcr_pkg::RST_EQUALIZER[lcr_pkg::EQ_GAIN_MSB:lcr_pkg::EQ_GAIN_LSB];
      lane1_input_boost_level_select_r <= lcr_pkg::RST_EQUALIZER[lcr_pkg::EQ_BOOST_MSB:lcr_pkg::EQ_BOOST_LSB];
    end else begin
      lane1_input_eq_enable_r          <= eq_enable_nxt;
      lane1_input_gain_stage_select_r  <= eq_gain_nxt;
      lane1_input_boost_level_select_r <= eq_boost_nxt;
    end
  end

  // ---------------------------------------------------------------
  // idle thresholds
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      lane1_input_idle_deassert_code_r <= lcr_pkg::RST_IDLE_THRESH[lcr_pkg::IDLE_DEA_MSB:lcr_pkg::IDLE_DEA_LSB];
      lane1_input_idle_assert_code_r   <= lcr_pkg::RST_IDLE_THRESH[lcr_pkg::IDLE_AS_MSB:lcr_pkg::IDLE_AS_LSB];
    end else begin
      lane1_input_idle_deassert_code_r <= thr_deassert_nxt;
      lane1_input_idle_assert_code_r   <= thr_assert_nxt;
    end
  end

  // ---------------------------------------------------------------
  // output swing
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      lane1_output_a_output_swing_r       <= lcr_pkg::RST_SWING_PRIMARY[lcr_pkg::SWING1_MSB:0];
      lane1_output_a_output_swing_level_r <= lcr_pkg::RST_SWING_SECOND;
      lane1_output_b_output_swing_r       <= lcr_pkg::RST_SWING_PRIMARY[lcr_pkg::SWING1_MSB:0];
      lane1_output_b_output_swing_level_r <= lcr_pkg::RST_SWING_SECOND;
      global_swing_scale_r                <= lcr_pkg::RST_GLOBAL_SWING[lcr_pkg::GSCALE_MSB:0];
    end else begin
      lane1_output_a_output_swing_r       <= a_swing_nxt;
      lane1_output_a_output_swing_level_r <= a_level_nxt;
      lane1_output_b_output_swing_r       <= b_swing_nxt;
      lane1_output_b_output_swing_level_r <= b_level_nxt;
      global_swing_scale_r                <= gscale_nxt;
    end
  end

endmodule

// ---- lcr_lane1_cfg_props.sv ----
`timescale 1ns/1ps
module lcr_lane1_cfg_props (
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       srst,
  // register port
  input wire logic       wr_en,
  input wire logic [7:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic       rd_en,
  input wire logic       rd_valid_r,
  // output b idle detect input and conditioning outputs
  input wire logic       lane1_output_b_idle_detect,
  input wire logic       lane1_input_eq_enable_r,
  input wire logic [1:0] lane1_input_gain_stage_select_r,
  input wire logic [2:0] lane1_input_boost_level_select_r,
  input wire logic [1:0] lane1_input_idle_deassert_code_r,
  input wire logic [1:0] lane1_input_idle_assert_code_r,
  input wire logic [6:0] lane1_output_a_output_swing_r,
  input wire logic [7:0] lane1_output_b_output_swing_level_r,
  input wire logic [1:0] global_swing_scale_r,
  input wire logic       lane1_output_b_mute_r,
  input wire logic       lane1_output_b_signal_detection_en_r
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  a_read_valid_pulse: assert property (rd_en |=> rd_valid_r)
    else $error("read not answered");
  a_read_valid_drop: assert property (!rd_en |=> !rd_valid_r)
    else $error("read valid not a single pulse");
  a_eq_code_forward: assert property (wr_en && wr_addr == 8'h3A |-> ##2
    {lane1_input_eq_enable_r, lane1_input_gain_stage_select_r, lane1_input_boost_level_select_r} == $past(wr_data[5:0], 2))
    else $error("equalizer field mismatch");
  a_swing_a_forward: assert property (wr_en && wr_addr == 8'h3B |-> ##2
    lane1_output_a_output_swing_r == $past(wr_data[6:0], 2)) else $error("swing a mismatch");
  a_level_b_forward: assert property (wr_en && wr_addr == 8'h43 |-> ##2
    lane1_output_b_output_swing_level_r == $past(wr_data, 2)) else $error("level b mismatch");
  a_idle_thresh_split: assert property (wr_en && wr_addr == 8'h3D |-> ##2
    {lane1_input_idle_deassert_code_r, lane1_input_idle_assert_code_r} == $past(wr_data[3:0], 2))
    else $error("threshold split wrong");
  a_global_scale_fwd: assert property (wr_en && wr_addr == 8'h47 |-> ##2
    global_swing_scale_r == $past(wr_data[1:0], 2)) else $error("global scale mismatch");
  a_manual_mute_sel: assert property (wr_en && wr_addr == 8'h40 && !wr_data[5] |-> ##2
    lane1_output_b_mute_r == $past(wr_data[4], 2) && !lane1_output_b_signal_detection_en_r)
    else $error("manual mute wrong");
  a_auto_mute_high: assert property ((lane1_output_b_signal_detection_en_r && lane1_output_b_idle_detect)[*4]
    |-> lane1_output_b_mute_r) else $error("auto mute missing");
  a_auto_mute_low: assert property ((lane1_output_b_signal_detection_en_r && !lane1_output_b_idle_detect)[*4]
    |-> !lane1_output_b_mute_r) else $error("auto mute stuck");
endmodule
bind lcr_lane1_cfg lcr_lane1_cfg_props u_props (.*);

// ---- lcr_lane1_cfg_test.sv ----
`timescale 1ns/1ps
module lcr_lane1_cfg_test;
  logic       sys_clk = 1'b0;
  logic       srst    = 1'b1;
  logic       det_a   = 1'b0;
  logic       det_b   = 1'b0;
  logic       wr_en, rd_en, rd_valid_r, eq_en, mute_a, mute_b, den_a, den_b, v;
  logic [7:0] wr_addr, wr_data, rd_addr, rd_data_r, lv_a, lv_b, got;
  logic [1:0] gain, dea, asr, scale;
  logic [2:0] boost;
  logic [6:0] sw_a, sw_b;
  int         n_mismatch = 0;
  int         n_checks   = 0;
  always #4 sys_clk = ~sys_clk;
  lcr_host u_host (.sys_clk(sys_clk), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .rd_en(rd_en),
    .rd_addr(rd_addr), .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r));
  lcr_lane1_cfg u_dut (.sys_clk(sys_clk), .srst(srst), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
    .rd_en(rd_en), .rd_addr(rd_addr), .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r),
    .lane1_output_a_idle_detect(det_a), .lane1_output_b_idle_detect(det_b),
    .lane1_input_eq_enable_r(eq_en), .lane1_input_gain_stage_select_r(gain),
    .lane1_input_boost_level_select_r(boost), .lane1_input_idle_deassert_code_r(dea),
    .lane1_input_idle_assert_code_r(asr), .lane1_output_a_output_swing_r(sw_a),
    .lane1_output_a_output_swing_level_r(lv_a), .lane1_output_b_output_swing_r(sw_b),
    .lane1_output_b_output_swing_level_r(lv_b), .global_swing_scale_r(scale),
    .lane1_output_a_mute_r(mute_a), .lane1_output_a_signal_detection_en_r(den_a),
    .lane1_output_b_mute_r(mute_b), .lane1_output_b_signal_detection_en_r(den_b));
  // ---------------------------------------------------------------
  // compare helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
    u_host.rd(a, got, v);
    chk({7'h00, v}, 8'h01, "read valid");
    chk(got, e, "read data");
  endtask
  task automatic settle;
    u_host.idle;
    @(negedge sys_clk);
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_defaults;
    chk({2'b00, eq_en, gain, boost}, 8'h20, "eq default");
    chk({4'h0, mute_b, den_b, mute_a, den_a}, 8'h00, "idle default");
    chk_rd(8'h3A, 8'h20);
    chk_rd(8'h3B, 8'h03);
    chk_rd(8'h3C, 8'h03);
    chk_rd(8'h3D, 8'h00);
    chk_rd(8'h39, 8'h00);
    chk_rd(8'h40, 8'h00);
    chk_rd(8'h42, 8'h03);
    chk_rd(8'h43, 8'h03);
    chk_rd(8'h47, 8'h02);
    $display("defaults done");
  endtask
  task automatic t_readback;
    u_host.wr(8'h3A, 8'h3D);
    u_host.wr(8'h3B, 8'h07);
    u_host.wr(8'h3C, 8'hA5);
    u_host.wr(8'h42, 8'h07);
    u_host.wr(8'h43, 8'h5A);
    u_host.wr(8'h41, 8'hFF);
    settle;
    chk({2'b00, eq_en, gain, boost}, 8'h3D, "eq fields");
    chk({1'b0, sw_a}, 8'h07, "swing a");
    chk(lv_a, 8'hA5, "level a");
    chk({1'b0, sw_b}, 8'h07, "swing b");
    chk(lv_b, 8'h5A, "level b");
    chk_rd(8'h3A, 8'h3D);
    chk_rd(8'h3C, 8'hA5);
    chk_rd(8'h43, 8'h5A);
    chk_rd(8'h41, 8'h00);
    $display("readback done");
  endtask
  task automatic t_codes;
    for (int c = 0; c < 4; c++) begin
      u_host.wr(8'h3D, {4'h0, c[1:0], ~c[1:0]});
      u_host.wr(8'h47, {6'h00, c[1:0]});
      settle;
      chk({4'h0, dea, asr}, {4'h0, c[1:0], ~c[1:0]}, "thresholds");
      chk({6'h00, scale}, {6'h00, c[1:0]}, "global scale");
      chk_rd(8'h47, {6'h00, c[1:0]});
    end
    $display("codes done");
  endtask
  task automatic t_mute;
    u_host.wr(8'h40, 8'h10);
    u_host.wr(8'h39, 8'h00);
    settle;
    chk({4'h0, mute_b, den_b, mute_a, den_a}, 8'h08, "manual mute");
    u_host.wr(8'h40, 8'h20);
    u_host.wr(8'h39, 8'h30);
    det_b = 1'b1;
    settle;
    repeat (3) @(negedge sys_clk);
    chk({4'h0, mute_b, den_b, mute_a, den_a}, 8'h0D, "auto mute");
    det_b = 1'b0;
    det_a = 1'b1;
    repeat (4) @(negedge sys_clk);
    chk({4'h0, mute_b, den_b, mute_a, den_a}, 8'h07, "auto follow");
    det_a = 1'b0;
    u_host.wr(8'h40, 8'h00);
    u_host.wr(8'h39, 8'h00);
    settle;
    chk({4'h0, mute_b, den_b, mute_a, den_a}, 8'h00, "manual on");
    $display("mute done");
  endtask
  // registers other than the two idle controls hold non-default values here, so a second reset must restore every default
  task automatic t_reset;
    srst = 1'b1;
    repeat (2) @(negedge sys_clk);
    srst = 1'b0;
    t_defaults;
    $display("reset done");
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge sys_clk);
    srst = 1'b0;
    t_defaults;
    t_readback;
    t_codes;
    t_mute;
    t_reset;
    stop_test;
  end
  // whole run is about 120 cycles; this bound is about twenty times that
  initial begin
    #20000;
    n_mismatch++;
    stop_test;
  end
endmodule

// ---- lcr_pkg.sv ----
package lcr_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int          DATA_W  = 8;
  localparam int          ADDR_W  = 8;
  localparam int          NUM_REG = 9;

  localparam logic [7:0] OFS_LANE1_INPUT_EQUALIZER       = 8'h3A;
  localparam logic [7:0] OFS_LANE1_OUT_A_SWING_PRIMARY   = 8'h3B;
  localparam logic [7:0] OFS_LANE1_OUT_A_SWING_SECONDARY = 8'h3C;
  localparam logic [7:0] OFS_LANE1_INPUT_IDLE_THRESHOLD  = 8'h3D;
  localparam logic [7:0] OFS_LANE1_OUT_A_IDLE_CONTROL    = 8'h39;
  localparam logic [7:0] OFS_LANE1_OUT_B_IDLE_CONTROL    = 8'h40;
  localparam logic [7:0] OFS_LANE1_OUT_B_SWING_PRIMARY   = 8'h42;
  localparam logic [7:0] OFS_LANE1_OUT_B_SWING_SECONDARY = 8'h43;
  localparam logic [7:0] OFS_GLOBAL_SWING_ADJUST         = 8'h47;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_EQUALIZER     = 8'h20;
  localparam logic [7:0] RST_SWING_PRIMARY = 8'h03;
  localparam logic [7:0] RST_SWING_SECOND  = 8'h03;
  localparam logic [7:0] RST_IDLE_THRESH   = 8'h00;
  localparam logic [7:0] RST_IDLE_CONTROL  = 8'h00;
  localparam logic [7:0] RST_GLOBAL_SWING  = 8'h02;
  localparam logic [7:0] RD_UNMAPPED       = 8'h00;

  // ---------------------------------------------------------------
  // table index order (entry 0 in the low byte)
  // ---------------------------------------------------------------
  localparam int IDX_EQ       = 0;
  localparam int IDX_A_SWING1 = 1;
  localparam int IDX_A_SWING2 = 2;
  localparam int IDX_IN_IDLE  = 3;
  localparam int IDX_A_IDLE   = 4;
  localparam int IDX_B_IDLE   = 5;
  localparam int IDX_B_SWING1 = 6;
  localparam int IDX_B_SWING2 = 7;
  localparam int IDX_GLOBAL   = 8;

  localparam logic [NUM_REG*8-1:0] REG_OFS = {
    OFS_GLOBAL_SWING_ADJUST, OFS_LANE1_OUT_B_SWING_SECONDARY, OFS_LANE1_OUT_B_SWING_PRIMARY,
    OFS_LANE1_OUT_B_IDLE_CONTROL, OFS_LANE1_OUT_A_IDLE_CONTROL, OFS_LANE1_INPUT_IDLE_THRESHOLD,
    OFS_LANE1_OUT_A_SWING_SECONDARY, OFS_LANE1_OUT_A_SWING_PRIMARY, OFS_LANE1_INPUT_EQUALIZER};

  localparam logic [NUM_REG*8-1:0] REG_RST = {
    RST_GLOBAL_SWING, RST_SWING_SECOND, RST_SWING_PRIMARY,
    RST_IDLE_CONTROL, RST_IDLE_CONTROL, RST_IDLE_THRESH,
    RST_SWING_SECOND, RST_SWING_PRIMARY, RST_EQUALIZER};

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int EQ_MSB        = 5;
  localparam int EQ_ENABLE_BIT = 5;
  localparam int EQ_GAIN_MSB   = 4;
  localparam int EQ_GAIN_LSB   = 3;
  localparam int EQ_BOOST_MSB  = 2;
  localparam int EQ_BOOST_LSB  = 0;
  localparam int SWING1_MSB    = 6;
  localparam int SWING2_MSB    = 7;
  localparam int IDLE_DEA_MSB  = 3;
  localparam int IDLE_DEA_LSB  = 2;
  localparam int IDLE_AS_MSB   = 1;
  localparam int IDLE_AS_LSB   = 0;
  localparam int IDLE_AUTO_BIT = 5;
  localparam int IDLE_SEL_BIT  = 4;
  localparam int GSCALE_MSB    = 1;

endpackage

// ---- lcr_reg_cell.sv ----
`timescale 1ns/1ps
module lcr_reg_cell #(
  parameter logic [7:0] OFS = 8'h00,
  parameter logic [7:0] RST = 8'h00
) (
  // clock and reset
  input  wire logic  sys_clk,
  input  wire logic  srst,
  // write port
  lcr_wr_if.dst      wr,
  // stored value
  output logic [7:0] value_r
);

  wire       hit;
  wire [7:0] value_nxt;

  assign hit       = wr.wr_en && (wr.wr_addr == OFS);
  // reserved bits are stored as written and read back unchanged
  assign value_nxt = hit ? wr.wr_data : value_r;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      value_r <= RST;
    end else begin
      value_r <= value_nxt;
    end
  end

endmodule

// ---- lcr_wr_if.sv ----
`timescale 1ns/1ps
interface lcr_wr_if;
  logic       wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  modport src (output wr_en, output wr_addr, output wr_data);
  modport dst (input wr_en, input wr_addr, input wr_data);
endinterface
